// ---- xmsw_cfg.svh ----
`ifndef XMSW_CFG_SVH
`define XMSW_CFG_SVH
// ************************************************************
// register byte addresses
// ************************************************************
`define XMSW_OFS_SECTOR_WAIT 8'h00
`define XMSW_OFS_KEEPER_MASK 8'h04
`define XMSW_OFS_CORE_CTRL 8'h08
`define XMSW_OFS_PORT_HIGH 8'h0c
`define XMSW_OFS_STATUS 8'h10
// ************************************************************
// field positions
// ************************************************************
`define XMSW_SRL_LSB 4
`define XMSW_LWAIT_LSB 2
`define XMSW_UWAIT_HI_BIT 1
`define XMSW_UWAIT_LO_BIT 6
`define XMSW_ENABLE_BIT 7
`define XMSW_KEEPER_BIT 7
`define XMSW_COMPAT_BIT 0
// ************************************************************
// writable masks and reset values
// ************************************************************
`define XMSW_SECTOR_WAIT_WMASK 8'h7e
`define XMSW_KEEPER_MASK_WMASK 8'h87
`define XMSW_CORE_CTRL_WMASK 8'hc1
`define XMSW_RESET_BYTE 8'h00
// ************************************************************
// address map
// ************************************************************
`define XMSW_EXT_BASE 16'h1100
`define XMSW_EXT_BASE_COMPAT 16'h1000
`define XMSW_SECTOR_STEP 16'h2000
// ************************************************************
// timing counts in cycles
// ************************************************************
`define XMSW_ALE_CYCLES 4'h1
`define XMSW_BASE_STROBE_CYCLES 4'h1
`endif

// ---- xmsw_pkg.sv ----
package xmsw_pkg;
  typedef enum logic [2:0] {
    XMSW_IDLE,
    XMSW_ADDR,
    XMSW_STROBE,
    XMSW_HOLD,
    XMSW_GAP
  } xmsw_phase_t;
  typedef struct packed {
    logic [7:0] sector_wait;
    logic [7:0] keeper_mask;
    logic [7:0] core_ctrl;
    logic [7:0] port_high;
  } xmsw_regs_t;
endpackage

// ---- xmsw_decode.sv ----
`timescale 1ns/1ps
`include "xmsw_cfg.svh"
// ************************************************************
// sector and wait decode
// ************************************************************
module xmsw_decode (
  input wire logic [15:0] addr,
  input wire logic [2:0] sector_limit,
  input wire logic [1:0] upper_code,
  input wire logic [1:0] lower_code,
  input wire logic compat_mode,
  output logic is_external,
  output logic [1:0] strobe_extra,
  output logic idle_extra
);
  logic [15:0] upper_start;
  logic [1:0] code;
  always_comb begin
    upper_start = {sector_limit, 13'h0000};
    if (compat_mode) begin
      is_external = addr >= `XMSW_EXT_BASE_COMPAT;
    end else begin
      is_external = addr >= `XMSW_EXT_BASE;
    end
    if (sector_limit == 3'h0 || addr >= upper_start) begin
      code = upper_code;
    end else begin
      code = lower_code;
    end
    unique case (code)
      2'b00: begin
        strobe_extra = 2'h0;
        idle_extra = 1'b0;
      end
      2'b01: begin
        strobe_extra = 2'h1;
        idle_extra = 1'b0;
      end
      2'b10: begin
        strobe_extra = 2'h2;
        idle_extra = 1'b0;
      end
      2'b11: begin
        strobe_extra = 2'h2;
        idle_extra = 1'b1;
      end
    endcase
  end
endmodule // xmsw_decode

// ---- xmsw_top.sv ----
`timescale 1ns/1ps
`include "xmsw_cfg.svh"
// Notes on behaviour
// - sector wait register bits 7 and 0 read zero.
// - limit zero makes whole external range one upper sector.
// - limit codes 1..7 put upper start at 0x2000 times code.
// - upper wait code high bit in sector register, low in core register.
// - lower wait code sits in sector register bits 3..2.
// - codes give 0, 1, 2 strobe waits, or 2 plus idle cycle.
// - keeper holds last driven bus value when not driving.
// - keeper works regardless of interface enable.
// - keeper/mask register bits 6..3 read zero.
// - mask zero drives all eight high address bits.
// - mask code k (1..6) releases top k high address pins; code 7 releases all eight.
// - released pins carry port register values.
// - no external access below 0x1100 outside compatibility mode.
// - compatibility mode starts external space at 0x1000.
// - enable bit gives pins their memory functions.
// - internal accesses never pulse read or write strobes.
// - low address valid on bus when latch strobe falls.
module xmsw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_req,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_done,
  output logic cpu_external,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] muxed_addr_data_bus_in,
  output logic [7:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe,
  output logic muxed_addr_data_bus_keep,
  output logic [7:0] high_address_bus,
  output logic [7:0] high_address_bus_oe,
  output logic addr_latch_strobe,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic pins_alternate
);
  typedef struct packed {
    xmsw_pkg::xmsw_regs_t regs;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    xmsw_pkg::xmsw_phase_t phase;
    logic [1:0] count;
    logic is_ext;
    logic wr;
    logic [1:0] extra;
    logic idle;
    logic [15:0] addr;
    logic [7:0] wbyte;
    logic done;
    logic [7:0] rbyte;
    logic [7:0] ad_out;
    logic ad_oe;
    logic ad_keep;
    logic [7:0] ha;
    logic [7:0] ha_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic alt;
  } xmsw_state_t;

  xmsw_state_t state_reg;
  xmsw_state_t state_next;
  logic dec_ext;
  logic [1:0] dec_extra;
  logic dec_idle;

  xmsw_decode u_decode (
    .addr(cpu_addr),
    .sector_limit(state_reg.regs.sector_wait[`XMSW_SRL_LSB +: 3]),
    .upper_code({state_reg.regs.sector_wait[`XMSW_UWAIT_HI_BIT],
                 state_reg.regs.core_ctrl[`XMSW_UWAIT_LO_BIT]}),
    .lower_code(state_reg.regs.sector_wait[`XMSW_LWAIT_LSB +: 2]),
    .compat_mode(state_reg.regs.core_ctrl[`XMSW_COMPAT_BIT]),
    .is_external(dec_ext),
    .strobe_extra(dec_extra),
    .idle_extra(dec_idle)
  );

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] nw,
                                            input logic [7:0] wmask, input logic en);
    byte_merge = en ? ((old & ~wmask) | (nw & wmask)) : old;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = a == `XMSW_OFS_SECTOR_WAIT || a == `XMSW_OFS_KEEPER_MASK ||
               a == `XMSW_OFS_CORE_CTRL || a == `XMSW_OFS_PORT_HIGH ||
               a == `XMSW_OFS_STATUS;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic ext_en;
    logic [2:0] mask;
    logic [7:0] keep_pins;
    ext_en = 1'b0;
    mask = 3'h0;
    keep_pins = 8'h00;
    state_next = state_reg;
    // axi write
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
      state_next.wready = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_hit(state_reg.aw_addr) ? 2'b00 : 2'b10;
      unique case (state_reg.aw_addr)
        `XMSW_OFS_SECTOR_WAIT: state_next.regs.sector_wait = byte_merge(
          state_reg.regs.sector_wait, state_reg.w_data[7:0],
          `XMSW_SECTOR_WAIT_WMASK, state_reg.w_strb[0]);
        `XMSW_OFS_KEEPER_MASK: state_next.regs.keeper_mask = byte_merge(
          state_reg.regs.keeper_mask, state_reg.w_data[7:0],
          `XMSW_KEEPER_MASK_WMASK, state_reg.w_strb[0]);
        `XMSW_OFS_CORE_CTRL: state_next.regs.core_ctrl = byte_merge(
          state_reg.regs.core_ctrl, state_reg.w_data[7:0],
          `XMSW_CORE_CTRL_WMASK, state_reg.w_strb[0]);
        `XMSW_OFS_PORT_HIGH: state_next.regs.port_high = byte_merge(
          state_reg.regs.port_high, state_reg.w_data[7:0], 8'hff, state_reg.w_strb[0]);
        default: begin
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end
    // axi read
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = addr_hit(s_axi_araddr) ? 2'b00 : 2'b10;
      unique case (s_axi_araddr)
        `XMSW_OFS_SECTOR_WAIT: state_next.rdata = {24'h000000, state_reg.regs.sector_wait};
        `XMSW_OFS_KEEPER_MASK: state_next.rdata = {24'h000000, state_reg.regs.keeper_mask};
        `XMSW_OFS_CORE_CTRL: state_next.rdata = {24'h000000, state_reg.regs.core_ctrl};
        `XMSW_OFS_PORT_HIGH: state_next.rdata = {24'h000000, state_reg.regs.port_high};
        `XMSW_OFS_STATUS: state_next.rdata = {28'h0000000, state_reg.is_ext,
                                              state_reg.phase};
        default: state_next.rdata = 32'h00000000;
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
    // ************************************************************
    // memory access sequencer
    // ************************************************************
    ext_en = state_reg.regs.core_ctrl[`XMSW_ENABLE_BIT];
    state_next.done = 1'b0;
    state_next.ale = 1'b0;
    unique case (state_reg.phase)
      xmsw_pkg::XMSW_IDLE: begin
        if (cpu_req) begin
          state_next.addr = cpu_addr;
          state_next.wbyte = cpu_wdata;
          state_next.wr = cpu_write;
          state_next.is_ext = ext_en && dec_ext;
          state_next.extra = dec_extra;
          state_next.idle = dec_idle;
          state_next.phase = xmsw_pkg::XMSW_ADDR;
          state_next.ale = ext_en;
          state_next.ad_out = cpu_addr[7:0];
          state_next.ad_oe = ext_en;
          state_next.count = 2'h0;
        end
      end
      xmsw_pkg::XMSW_ADDR: begin
        // latch strobe falls while address still driven
        state_next.phase = xmsw_pkg::XMSW_STROBE;
        if (state_reg.is_ext) begin
          state_next.rd_n = state_reg.wr;
          state_next.wr_n = !state_reg.wr;
          state_next.ad_out = state_reg.wbyte;
          state_next.ad_oe = state_reg.wr;
        end else begin
          state_next.ad_oe = 1'b0;
        end
      end
      xmsw_pkg::XMSW_STROBE: begin
        if (state_reg.is_ext && state_reg.count != state_reg.extra) begin
          state_next.count = state_reg.count + 2'h1;
        end else begin
          if (!state_reg.wr) begin
            state_next.rbyte = muxed_addr_data_bus_in;
          end
          state_next.rd_n = 1'b1;
          state_next.wr_n = 1'b1;
          state_next.phase = xmsw_pkg::XMSW_HOLD;
        end
      end
      xmsw_pkg::XMSW_HOLD: begin
        state_next.ad_oe = 1'b0;
        state_next.done = !(state_reg.is_ext && state_reg.idle);
        state_next.phase = (state_reg.is_ext && state_reg.idle) ?
                           xmsw_pkg::XMSW_GAP : xmsw_pkg::XMSW_IDLE;
      end
      xmsw_pkg::XMSW_GAP: begin
        state_next.done = 1'b1;
        state_next.phase = xmsw_pkg::XMSW_IDLE;
      end
      default: state_next.phase = xmsw_pkg::XMSW_IDLE;
    endcase
    // ************************************************************
    // pin control
    // ************************************************************
    state_next.alt = ext_en;
    state_next.ad_keep = state_reg.regs.keeper_mask[`XMSW_KEEPER_BIT];
    mask = state_reg.regs.keeper_mask[2:0];
    for (int i = 0; i < 8; i++) begin
      keep_pins[i] = ext_en && (i < 8 - int'(mask)) && !(mask == 3'h7);
    end
    for (int i = 0; i < 8; i++) begin
      // released pins show port register values
      state_next.ha[i] = keep_pins[i] ? state_next.addr[8 + i] :
                         state_reg.regs.port_high[i];
    end
    state_next.ha_oe = keep_pins;
    if (!ext_en) begin
      state_next.ad_oe = 1'b0;
      state_next.rd_n = 1'b1;
      state_next.wr_n = 1'b1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.rd_n <= 1'b1;
      state_reg.wr_n <= 1'b1;
      state_reg.phase <= xmsw_pkg::XMSW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign cpu_done = state_reg.done;
  assign cpu_external = state_reg.is_ext;
  assign cpu_rdata = state_reg.rbyte;
  assign muxed_addr_data_bus_out = state_reg.ad_out;
  assign muxed_addr_data_bus_oe = state_reg.ad_oe;
  assign muxed_addr_data_bus_keep = state_reg.ad_keep;
  assign high_address_bus = state_reg.ha;
  assign high_address_bus_oe = state_reg.ha_oe;
  assign addr_latch_strobe = state_reg.ale;
  assign read_strobe_n = state_reg.rd_n;
  assign write_strobe_n = state_reg.wr_n;
  assign pins_alternate = state_reg.alt;
endmodule // xmsw_top

// ---- xmsw_sram_model.sv ----
`timescale 1ns/1ps
// ****
// external sram behind address latch
// ****
module xmsw_sram_model (
  input wire logic aclk,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe,
  input wire logic keep,
  input wire logic [7:0] hi,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:32767];
  logic [7:0] lo;
  logic [7:0] last = 8'h00;
  logic [14:0] idx;
  // latch follows bus while strobe high, holds after fall
  always @(posedge aclk) begin
    if (ale) lo <= ad_out;
  end
  // top address line left unconnected: 32 kb aliases
  assign idx = {hi[6:0], lo};
  always @(posedge aclk) begin
    if (!wr_n) mem[idx] <= ad_out;
    last <= ad_in;
  end
  // released bus: keeper holds, else it wanders
  assign ad_in = ad_oe ? ad_out : (!rd_n ? mem[idx] : (keep ? last : ~last));
endmodule // xmsw_sram_model

// ---- xmsw_top_asserts.sv ----
`timescale 1ns/1ps
// ****
// port checker
// ****
module xmsw_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_done,
  input wire logic cpu_external,
  input wire logic muxed_addr_data_bus_oe,
  input wire logic [7:0] high_address_bus,
  input wire logic [7:0] high_address_bus_oe,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic pins_alternate
);
  logic strb_n;
  logic [7:0] cpu_hi;
  assign strb_n = read_strobe_n & write_strobe_n;
  assign cpu_hi = cpu_addr[15:8];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence strb_go;
    $fell(strb_n);
  endsequence
  sequence strb_end;
    $rose(strb_n);
  endsequence
  strobe_len_a: assert property (strb_go |-> ##[1:3] strb_n)
    else $error("strobe held too long");
  done_gap_a: assert property (strb_end |-> ##[1:2] cpu_done)
    else $error("done not after strobe end");
  ext_only_a: assert property (strb_go |-> cpu_external)
    else $error("strobe on internal access");
  ale_drive_a: assert property (addr_latch_strobe |-> muxed_addr_data_bus_oe)
    else $error("bus not driven at latch strobe");
  ale_quiet_a: assert property (addr_latch_strobe |-> strb_n ##1 !addr_latch_strobe)
    else $error("latch strobe overlaps strobe");
  hi_addr_a: assert property ($rose(addr_latch_strobe) |->
    ((high_address_bus ^ $past(cpu_hi)) & high_address_bus_oe) == 8'h00)
    else $error("high address wrong");
  mask_shape_a: assert property (pins_alternate |-> high_address_bus_oe inside
    {8'hff, 8'h7f, 8'h3f, 8'h1f, 8'h0f, 8'h07, 8'h03, 8'h00})
    else $error("high address enable pattern bad");
  rel_off_a: assert property (!pins_alternate |-> high_address_bus_oe == 8'h00)
    else $error("address pins used while disabled");
endmodule // xmsw_top_asserts
bind xmsw_top xmsw_top_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .cpu_addr(cpu_addr),
  .cpu_done(cpu_done), .cpu_external(cpu_external),
  .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe),
  .high_address_bus(high_address_bus), .high_address_bus_oe(high_address_bus_oe),
  .addr_latch_strobe(addr_latch_strobe), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .pins_alternate(pins_alternate));

// ---- xmsw_tb.sv ----
`timescale 1ns/1ps
// ****
// testbench
// ****
module testbench;
  logic aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara, cpu_wdata, cpu_rdata, ad_in, ad_out, hi, hi_oe, v8;
  logic [31:0] wd, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic cpu_req, cpu_write, cpu_done, cpu_ext, ad_oe, keep, ale, rd_n, wr_n, alt;
  logic [15:0] cpu_addr;
  int fail_count = 0, n_tests = 0, cyc = 0, n, c, k;
  xmsw_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_done(cpu_done),
    .cpu_external(cpu_ext), .cpu_rdata(cpu_rdata), .muxed_addr_data_bus_in(ad_in),
    .muxed_addr_data_bus_out(ad_out), .muxed_addr_data_bus_oe(ad_oe),
    .muxed_addr_data_bus_keep(keep), .high_address_bus(hi), .high_address_bus_oe(hi_oe),
    .addr_latch_strobe(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .pins_alternate(alt));
  xmsw_sram_model i_mem (.aclk(aclk), .ad_out(ad_out), .ad_oe(ad_oe), .keep(keep), .hi(hi),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk) begin
      awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; br <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ta = awv & awr; tw = wv & wr_rdy; tb = bv; r = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (tb !== 1'b1);
    br <= 1'b0;
    // let the register fields reach the pins before anyone looks
    #1;
    chk("bresp", r, er);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk) begin
      ara <= a; arv <= 1'b1; rr <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ta = arv & arr; tr = rv;
      if (tr === 1'b1) chk("rdata", rdat, e);
      if (tr === 1'b1) chk("rresp", rresp, er);
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end while (tr !== 1'b1);
    rr <= 1'b0;
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk) begin
      cpu_req <= 1'b1; cpu_write <= w; cpu_addr <= a; cpu_wdata <= d;
    end
    @(posedge aclk) cpu_req <= 1'b0;
    // count from the edge that launched the request
    n = 1;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (cpu_done !== 1'b1 && n < 20);
    v8 = cpu_rdata;
  endtask
  // access length and external flag
  task ck(input logic [15:0] a, input int e, input logic x);
    acc(1'b0, a, 8'h00);
    chk("cycles", n, e);
    chk("external", cpu_ext, x);
  endtask
  function automatic int wt(input int code);
    return 4 + (code == 0 ? 0 : (code == 1 ? 1 : 2)) + (code == 3 ? 1 : 0);
  endfunction
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    aresetn = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; wstrb = 4'hf;
    cpu_req = 1'b0; cpu_write = 1'b0; cpu_addr = 16'h0; cpu_wdata = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h0, 2'b00);
    rchk(8'h04, 32'h0, 2'b00);
    wr(8'h00, 32'hff, 2'b00);
    rchk(8'h00, 32'h7e, 2'b00);
    wr(8'h04, 32'hff, 2'b00);
    rchk(8'h04, 32'h87, 2'b00);
    wr(8'h20, 32'hff, 2'b10);
    rchk(8'h20, 32'h0, 2'b10);
    chk("keep", keep, 1'b1);
    chk("hi_oe", hi_oe, 8'h00);
    wr(8'h04, 32'h0, 2'b00);
    chk("keep", keep, 1'b0);
    wr(8'h08, 32'h80, 2'b00);
    chk("alt", alt, 1'b1);
    wr(8'h0c, 32'h5a, 2'b00);
    for (k = 0; k < 8; k++) begin
      wr(8'h04, k, 2'b00);
      v8 = (k == 7) ? 8'h00 : (8'hff >> k);
      chk("hi_oe", hi_oe, v8);
      chk("port", hi & ~hi_oe, 8'h5a & ~v8);
    end
    wr(8'h04, 32'h0, 2'b00);
    wr(8'h0c, 32'h0, 2'b00);
    $display("test registers and pins done");
    for (c = 0; c < 4; c++) begin
      wr(8'h00, 32'h10 | (c << 2) | (((3 - c) >> 1) << 1), 2'b00);
      wr(8'h08, 32'h80 | (((3 - c) & 1) << 6), 2'b00);
      ck(16'h1fff, wt(c), 1'b1);
      ck(16'h2000, wt(3 - c), 1'b1);
    end
    wr(8'h08, 32'hc0, 2'b00);
    for (k = 1; k < 8; k++) begin
      wr(8'h00, (k << 4) | 2, 2'b00);
      ck(k * 16'h2000, 7, 1'b1);
      ck(k * 16'h2000 - 1, 4, 1'b1);
    end
    wr(8'h00, 32'h02, 2'b00);
    ck(16'h1100, 7, 1'b1);
    ck(16'h10ff, 4, 1'b0);
    ck(16'h1000, 4, 1'b0);
    wr(8'h08, 32'hc1, 2'b00);
    ck(16'h1000, 7, 1'b1);
    ck(16'h0fff, 4, 1'b0);
    wr(8'h08, 32'h80, 2'b00);
    wr(8'h00, 32'h0, 2'b00);
    $display("test wait states done");
    acc(1'b1, 16'h1234, 8'ha5);
    acc(1'b0, 16'h1234, 8'h00);
    chk("read", v8, 8'ha5);
    wr(8'h04, 32'h03, 2'b00);
    acc(1'b1, 16'h2001, 8'haa);
    wr(8'h04, 32'h0, 2'b00);
    acc(1'b1, 16'h2001, 8'h55);
    acc(1'b0, 16'h8001, 8'h00);
    chk("alias", v8, 8'haa);
    acc(1'b0, 16'h2001, 8'h00);
    chk("read", v8, 8'h55);
    rchk(8'h10, 32'h8, 2'b00);
    $display("test data path done");
    conclude();
  end
endmodule // testbench
